// *** hw/pcss_pkg.sv ***
// Constants and carrier types for the two-socket card signalling block
// Notes on behaviour
// - Each socket moves card data over its own two-way 16-bit data bus.
// - Each socket gets a 26-bit card address: 64 MByte memory space, 64 KByte I/O space.
// - The I/O read strobe goes low only while the attribute select is also low.
// - The I/O write strobe goes low only while the attribute select is also low.
// - The socket A select pin is an input during reset, sampled once as reset ends.
// - A low strap keeps socket A a card socket; a high strap hands its pins to IDE.
// - The captured strap is held in a configuration register readable by software; here it is a flop driven out on ide_pinout_strap, with no software read path.
// - With a low strap, socket A's select pin turns into the attribute select output.
// - The attribute select stays high through every common memory access.
// - With attribute select low, memory strobes reach attribute memory, I/O strobes reach I/O ports.
// - The output enable strobe goes low to read memory data from the card.
// - Two low-active chip enables: the first for even bytes, the second for odd bytes.
// - The write enable strobe gates memory write data into the card.
package pcss_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS = 20;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 26;
  localparam int IO_ADDR_W = 16;
  localparam int NUM_SOCK = 2;
  localparam logic [1:0] CE_IDLE = 2'h3;
  localparam logic [9:0] IO_ADDR_HI_ZERO = 10'h000;

  // ----------------------------------------
  // Access kinds and sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    KIND_MEM_RD = 3'b000,
    KIND_MEM_WR = 3'b001,
    KIND_ATTR_RD = 3'b010,
    KIND_ATTR_WR = 3'b011,
    KIND_IO_RD = 3'b100,
    KIND_IO_WR = 3'b101
  } pcss_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } pcss_state_e;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] byte_en;
  } pcss_req_s;

  typedef struct packed {
    logic done;
    logic err;
    logic [DATA_W-1:0] rdata;
  } pcss_ans_s;

endpackage : pcss_pkg

// *** hw/pcss_top.sv ***
// Two-socket card access sequencer with socket A IDE strap capture
`timescale 1ns/100ps
module pcss_top
  import pcss_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire pcss_req_s sock_a_req,
  input wire pcss_req_s sock_b_req,
  output logic sock_a_req_ready,
  output logic sock_b_req_ready,
  output pcss_ans_s sock_a_ans,
  output pcss_ans_s sock_b_ans,
  input wire logic [DATA_W-1:0] sock_a_card_data,
  output logic [DATA_W-1:0] sock_a_card_data_drv,
  output logic sock_a_card_data_oe,
  input wire logic [DATA_W-1:0] sock_b_card_data,
  output logic [DATA_W-1:0] sock_b_card_data_drv,
  output logic sock_b_card_data_oe,
  output logic [ADDR_W-1:0] sock_a_card_addr,
  output logic [ADDR_W-1:0] sock_b_card_addr,
  output logic [1:0] sock_a_chip_en_n,
  output logic [1:0] sock_b_chip_en_n,
  output logic sock_a_out_en_n,
  output logic sock_b_out_en_n,
  output logic sock_a_write_en_n,
  output logic sock_b_write_en_n,
  output logic sock_a_io_read_n,
  output logic sock_b_io_read_n,
  output logic sock_a_io_write_n,
  output logic sock_b_io_write_n,
  input wire logic sock_a_attr_sel_ide_strap,
  output logic sock_a_attr_sel_ide_strap_drv,
  output logic sock_a_attr_sel_ide_strap_oe,
  output logic sock_b_attr_sel_n,
  output logic ide_pinout_strap
);
  localparam int OE_DLY = int'(SETUP_CYC) + 1;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic strap_done_reg, strap_reg, a_sel_oe_reg;
  // Pin is only sampled on the first edge after release, never by the reset itself
  // strap sampled once
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_done_reg <= 1'b0;
      strap_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      strap_reg <= sock_a_attr_sel_ide_strap;
    end
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      a_sel_oe_reg <= 1'b0;
    else
      a_sel_oe_reg <= strap_done_reg && !strap_reg;
  end
  assign ide_pinout_strap = strap_reg;
  assign sock_a_attr_sel_ide_strap_oe = a_sel_oe_reg;

  // ----------------------------------------
  // Per-socket sequencers
  // ----------------------------------------
  pcss_req_s req [NUM_SOCK];
  pcss_state_e state_reg [NUM_SOCK];
  pcss_ans_s ans_reg [NUM_SOCK];
  logic [3:0] cnt_reg [NUM_SOCK];
  logic [2:0] kind_reg [NUM_SOCK];
  logic [1:0] be_reg [NUM_SOCK], ce_n_reg [NUM_SOCK];
  logic [ADDR_W-1:0] addr_reg [NUM_SOCK];
  logic [DATA_W-1:0] din [NUM_SOCK], dout_reg [NUM_SOCK];
  logic sock_en [NUM_SOCK], ready_reg [NUM_SOCK], doe_reg [NUM_SOCK], reg_n_reg [NUM_SOCK];
  logic oe_n_reg [NUM_SOCK], we_n_reg [NUM_SOCK], iord_n_reg [NUM_SOCK], iowr_n_reg [NUM_SOCK];
  assign req[0] = sock_a_req;
  assign req[1] = sock_b_req;
  assign din[0] = sock_a_card_data;
  assign din[1] = sock_b_card_data;
  // IDE strap takes socket A away
  assign sock_en[0] = strap_done_reg && !strap_reg;
  assign sock_en[1] = strap_done_reg;
  genvar s;
  generate
    for (s = 0; s < NUM_SOCK; s++)
    begin : g_sock
      logic take, legal, is_rd, is_io, is_attr, last;
      assign take = req[s].valid && ready_reg[s] && state_reg[s] == ST_IDLE;
      assign legal = req[s].kind <= 3'(KIND_IO_WR);
      assign is_rd = !req[s].kind[0];
      assign is_io = req[s].kind[2];
      assign is_attr = req[s].kind[1];
      assign last = cnt_reg[s] == 4'h0;

      // Sequencer: setup, strobe, hold; bad or disabled requests bounce at once
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          state_reg[s] <= ST_IDLE;
          cnt_reg[s] <= 4'h0;
          kind_reg[s] <= 3'h0;
          be_reg[s] <= 2'h0;
        end
        else
        begin
          unique case (state_reg[s])
            ST_IDLE:
              if (take && legal && sock_en[s])
              begin
                state_reg[s] <= ST_SETUP;
                cnt_reg[s] <= SETUP_CYC - 4'h1;
                kind_reg[s] <= req[s].kind;
                be_reg[s] <= req[s].byte_en;
              end
            ST_SETUP:
              if (last)
              begin
                state_reg[s] <= ST_STROBE;
                cnt_reg[s] <= STROBE_CYC - 4'h1;
              end
              else
                cnt_reg[s] <= cnt_reg[s] - 4'h1;
            ST_STROBE:
              if (last)
              begin
                state_reg[s] <= ST_HOLD;
                cnt_reg[s] <= HOLD_CYC - 4'h1;
              end
              else
                cnt_reg[s] <= cnt_reg[s] - 4'h1;
            ST_HOLD:
              if (last)
                state_reg[s] <= ST_IDLE;
              else
                cnt_reg[s] <= cnt_reg[s] - 4'h1;
          endcase
        end
      end

      // Ready drops the cycle a request is taken, returns once hold ends
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          ready_reg[s] <= 1'b0;
        else
          ready_reg[s] <= (state_reg[s] == ST_IDLE && !take) || (state_reg[s] == ST_HOLD && last);
      end
      // Answer: one-cycle done, read data caught on the last strobe cycle
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          ans_reg[s] <= '0;
        else
        begin
          ans_reg[s].done <= (take && !(legal && sock_en[s])) || (state_reg[s] == ST_HOLD && last);
          ans_reg[s].err <= take && !(legal && sock_en[s]);
          if (state_reg[s] == ST_STROBE && last && !kind_reg[s][0])
            ans_reg[s].rdata <= din[s];
        end
      end
      // Address, data, chip enables and attribute select set up before the strobe
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          addr_reg[s] <= '0;
          dout_reg[s] <= '0;
          doe_reg[s] <= 1'b0;
          ce_n_reg[s] <= CE_IDLE;
          reg_n_reg[s] <= 1'b1;
        end
        else if (take && legal && sock_en[s])
        begin
          // I/O space keeps upper address bits zero
          addr_reg[s] <= is_io ? {IO_ADDR_HI_ZERO, req[s].addr[IO_ADDR_W-1:0]} : req[s].addr;
          dout_reg[s] <= req[s].wdata;
          // bridge drives data only for writes
          doe_reg[s] <= !is_rd;
          // CE1 even lane, CE2 odd lane
          ce_n_reg[s] <= ~req[s].byte_en;
          // select low for attribute and I/O
          reg_n_reg[s] <= !(is_io || is_attr);
        end
        else if (state_reg[s] == ST_HOLD && last)
        begin
          doe_reg[s] <= 1'b0;
          ce_n_reg[s] <= CE_IDLE;
          reg_n_reg[s] <= 1'b1;
        end
      end
      // Strobes: only one of the four ever low, and only in the strobe phase
      // memory and I/O strobes exclusive
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          oe_n_reg[s] <= 1'b1;
          we_n_reg[s] <= 1'b1;
          iord_n_reg[s] <= 1'b1;
          iowr_n_reg[s] <= 1'b1;
        end
        else
        begin
          oe_n_reg[s] <= !(state_reg[s] == ST_SETUP && last && kind_reg[s][2:1] != 2'b10 && !kind_reg[s][0])
            && !(state_reg[s] == ST_STROBE && !last && oe_n_reg[s] == 1'b0);
          we_n_reg[s] <= !(state_reg[s] == ST_SETUP && last && kind_reg[s][2:1] != 2'b10 && kind_reg[s][0])
            && !(state_reg[s] == ST_STROBE && !last && we_n_reg[s] == 1'b0);
          // I/O read only with select low
          iord_n_reg[s] <= !(state_reg[s] == ST_SETUP && last && kind_reg[s] == KIND_IO_RD && !reg_n_reg[s])
            && !(state_reg[s] == ST_STROBE && !last && iord_n_reg[s] == 1'b0);
          // I/O write only with select low
          iowr_n_reg[s] <= !(state_reg[s] == ST_SETUP && last && kind_reg[s] == KIND_IO_WR && !reg_n_reg[s])
            && !(state_reg[s] == ST_STROBE && !last && iowr_n_reg[s] == 1'b0);
        end
      end

      // ----------------------------------------
      // Checks
      // ----------------------------------------
      sequence s_take_mem_rd;
        take && legal && sock_en[s] && req[s].kind == KIND_MEM_RD;
      endsequence
      chk_strobe_exclusive: assert property (@(posedge mclk) disable iff (!rst_b)
        !((!oe_n_reg[s] || !we_n_reg[s]) && (!iord_n_reg[s] || !iowr_n_reg[s])))
        else $error("memory and I/O strobes low together");
      chk_io_read_sel: assert property (@(posedge mclk) disable iff (!rst_b)
        !iord_n_reg[s] |-> !reg_n_reg[s] && !doe_reg[s])
        else $error("I/O read without attribute select");
      chk_io_write_sel: assert property (@(posedge mclk) disable iff (!rst_b)
        !iowr_n_reg[s] |-> !reg_n_reg[s] && doe_reg[s])
        else $error("I/O write without attribute select");
      chk_common_sel_high: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg[s] != ST_IDLE && kind_reg[s][2:1] == 2'b00 |-> reg_n_reg[s])
        else $error("attribute select low in common memory access");
      chk_read_oe_time: assert property (@(posedge mclk) disable iff (!rst_b)
        s_take_mem_rd |-> ##OE_DLY !oe_n_reg[s] && !doe_reg[s] ##1 !oe_n_reg[s])
        else $error("output enable late or bus driven during read");
      chk_ce_lanes: assert property (@(posedge mclk) disable iff (!rst_b)
        !oe_n_reg[s] || !we_n_reg[s] |-> ce_n_reg[s] == ~be_reg[s])
        else $error("chip enables do not match byte lanes");
      chk_write_data_on: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(we_n_reg[s]) |-> doe_reg[s] && $stable(dout_reg[s]) && $past(doe_reg[s]))
        else $error("write enable without driven data");
      chk_io_addr_range: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg[s] != ST_IDLE && kind_reg[s][2] |-> addr_reg[s][ADDR_W-1:IO_ADDR_W] == IO_ADDR_HI_ZERO)
        else $error("I/O address outside 64 KByte");
    end
  endgenerate
  chk_strap_input: assert property (@(posedge mclk) disable iff (!rst_b)
    !strap_done_reg |=> !a_sel_oe_reg)
    else $error("strap pin driven before capture");
  chk_strap_held: assert property (@(posedge mclk) disable iff (!rst_b)
    strap_done_reg && $past(strap_done_reg) |-> $stable(ide_pinout_strap))
    else $error("captured strap changed");
  chk_ide_refuse: assert property (@(posedge mclk) disable iff (!rst_b)
    g_sock[0].take && strap_reg |=> sock_a_ans.done && sock_a_ans.err)
    else $error("socket A access while pins belong to IDE");
  chk_sel_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    strap_done_reg && !strap_reg ##1 1'b1 |-> sock_a_attr_sel_ide_strap_oe)
    else $error("select pin not driven with low strap");
  // ----------------------------------------
  // Pin mapping, all straight from flops
  // ----------------------------------------
  assign sock_a_req_ready = ready_reg[0];
  assign sock_b_req_ready = ready_reg[1];
  assign sock_a_ans = ans_reg[0];
  assign sock_b_ans = ans_reg[1];
  assign sock_a_card_data_drv = dout_reg[0];
  assign sock_b_card_data_drv = dout_reg[1];
  assign sock_a_card_data_oe = doe_reg[0];
  assign sock_b_card_data_oe = doe_reg[1];
  assign sock_a_card_addr = addr_reg[0];
  assign sock_b_card_addr = addr_reg[1];
  assign sock_a_chip_en_n = ce_n_reg[0];
  assign sock_b_chip_en_n = ce_n_reg[1];
  assign sock_a_out_en_n = oe_n_reg[0];
  assign sock_b_out_en_n = oe_n_reg[1];
  assign sock_a_write_en_n = we_n_reg[0];
  assign sock_b_write_en_n = we_n_reg[1];
  assign sock_a_io_read_n = iord_n_reg[0];
  assign sock_b_io_read_n = iord_n_reg[1];
  assign sock_a_io_write_n = iowr_n_reg[0];
  assign sock_b_io_write_n = iowr_n_reg[1];
  assign sock_a_attr_sel_ide_strap_drv = reg_n_reg[0];
  assign sock_b_attr_sel_n = reg_n_reg[1];
endmodule : pcss_top

// *** dv/pcss_card_model.sv ***
// Behavioural card for one socket: main, attribute and I/O spaces
`timescale 1ns/100ps
module pcss_card_model
  import pcss_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0] ce_n,
  input wire logic sel_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [DATA_W-1:0] bus,
  output logic [DATA_W-1:0] card_q
);
  logic [15:0] mem [logic [27:0]];
  logic [15:0] last_q = 16'h0000;
  logic [27:0] key;

  // Unwritten words read back as a pattern of their key
  function automatic logic [15:0] fill(input logic [27:0] k);
    return k[15:0] ^ {k[27:26], 14'h2A5B};
  endfunction : fill

  assign key = {sel_n ? 2'h0 : (ior_n && iow_n) ? 2'h1 : 2'h2, addr};

  // read drive
  // Released bus shows the inverse of the last word, not a kind value
  always @(key or oe_n or ior_n or sel_n)
  begin
    if (!oe_n || (!ior_n && !sel_n))
    begin
      card_q = mem.exists(key) ? mem[key] : fill(key);
      last_q = card_q;
    end
    else
      card_q = ~last_q;
  end

  task automatic store(input logic [27:0] k);
    logic [15:0] old;
    if (!$isunknown(k))
    begin
      old = mem.exists(k) ? mem[k] : fill(k);
      mem[k] = {ce_n[1] ? old[15:8] : bus[15:8], ce_n[0] ? old[7:0] : bus[7:0]};
    end
  endtask : store

  // memory write taken as the strobe ends
  always @(posedge we_n)
    store(key);

  // I/O write ignored with the select high
  always @(posedge iow_n)
    if (sel_n === 1'b0)
      store({2'h2, addr});
endmodule : pcss_card_model

// *** dv/tb_pcss_top.sv ***
// Self-checking bench: card models on both sockets, random accesses
`timescale 1ns/100ps
module tb_pcss_top
  import pcss_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic strap_pull = 1'b0;
  pcss_req_s req_a = '0;
  pcss_req_s req_b = '0;
  int fails = 0;
  int total_checks = 0;
  int seed = 32'h30790787;
  logic rdy_a, rdy_b, doe_a, doe_b, sel_drv, sel_oe, sel_a, sel_b, strap;
  logic cur = 1'b0;
  logic oe_a, oe_b, we_a, we_b, ior_a, ior_b, iow_a, iow_b, p_sel, p_doe, p_rdy;
  logic [15:0] bus_a, bus_b, drv_a, drv_b, q_a, q_b, p_drv;
  logic [25:0] addr_a, addr_b, p_addr;
  logic [1:0] ce_a, ce_b, p_ce;
  logic [3:0] p_stb;
  pcss_ans_s ans_a, ans_b, p_ans;
  logic [15:0] shadow [logic [28:0]];

  initial
    forever #5 mclk = ~mclk;

  // Wire levels: select pin has its strap resistor when undriven
  assign bus_a = doe_a ? drv_a : q_a;
  assign bus_b = doe_b ? drv_b : q_b;
  assign sel_a = sel_oe ? sel_drv : strap_pull;
  assign {p_addr, p_ce, p_stb, p_sel, p_doe, p_rdy, p_drv, p_ans} = cur ?
    {addr_b, ce_b, oe_b, we_b, ior_b, iow_b, sel_b, doe_b, rdy_b, drv_b, ans_b} :
    {addr_a, ce_a, oe_a, we_a, ior_a, iow_a, sel_a, doe_a, rdy_a, drv_a, ans_a};

  pcss_top DUT (.mclk(mclk), .rst_b(rst_b), .sock_a_req(req_a), .sock_b_req(req_b),
    .sock_a_req_ready(rdy_a), .sock_b_req_ready(rdy_b), .sock_a_ans(ans_a), .sock_b_ans(ans_b),
    .sock_a_card_data(bus_a), .sock_a_card_data_drv(drv_a), .sock_a_card_data_oe(doe_a),
    .sock_b_card_data(bus_b), .sock_b_card_data_drv(drv_b), .sock_b_card_data_oe(doe_b),
    .sock_a_card_addr(addr_a), .sock_b_card_addr(addr_b), .sock_a_chip_en_n(ce_a), .sock_b_chip_en_n(ce_b),
    .sock_a_out_en_n(oe_a), .sock_b_out_en_n(oe_b), .sock_a_write_en_n(we_a), .sock_b_write_en_n(we_b),
    .sock_a_io_read_n(ior_a), .sock_b_io_read_n(ior_b), .sock_a_io_write_n(iow_a),
    .sock_b_io_write_n(iow_b), .sock_a_attr_sel_ide_strap(sel_a), .sock_a_attr_sel_ide_strap_drv(sel_drv),
    .sock_a_attr_sel_ide_strap_oe(sel_oe), .sock_b_attr_sel_n(sel_b), .ide_pinout_strap(strap));

  pcss_card_model card_a (.addr(addr_a), .ce_n(ce_a), .sel_n(sel_a), .oe_n(oe_a), .we_n(we_a),
    .ior_n(ior_a), .iow_n(iow_a), .bus(bus_a), .card_q(q_a));
  pcss_card_model card_b (.addr(addr_b), .ce_n(ce_b), .sel_n(sel_b), .oe_n(oe_b), .we_n(we_b),
    .ior_n(ior_b), .iow_n(iow_b), .bus(bus_b), .card_q(q_b));

  function automatic logic [15:0] fill(input logic [27:0] k);
    return k[15:0] ^ {k[27:26], 14'h2A5B};
  endfunction : fill

  // An I/O strobe needs the select low and no memory strobe
  function automatic logic mix_ok(input logic s, input logic o, input logic w, input logic r, input logic x);
    return !((!r || !x) && (s || !o || !w));
  endfunction : mix_ok

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Reset with a given strap level, then look at the captured strap
  task automatic restart(input logic lvl);
    @(posedge mclk);
    rst_b <= 1'b0;
    strap_pull <= lvl;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("in_reset", {p_rdy, sel_oe, p_stb, p_ce}, 8'h3F);
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(negedge mclk);
    check("strap", {strap, sel_oe, sel_a}, {lvl, !lvl, 1'b1});
  endtask : restart

  // One access: pins looked at mid-strobe, answer at done
  task automatic access(input logic s, input logic [2:0] kind, input logic [25:0] ad, input logic [15:0] wd,
                        input logic [1:0] be, input logic refuse);
    logic [28:0] k;
    logic [15:0] old;
    int n;
    k = {s, kind[2] ? 2'h2 : {1'b0, kind[1]}, kind[2] ? {10'h000, ad[15:0]} : ad};
    old = shadow.exists(k) ? shadow[k] : fill(k[27:0]);
    cur = s;
    @(posedge mclk);
    if (s)
      req_b <= '{1'b1, kind, ad, wd, be};
    else
      req_a <= '{1'b1, kind, ad, wd, be};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (p_rdy !== 1'b1 && n < 40);
    check("taken", n < 40, 1'b1);
    req_a.valid <= 1'b0;
    req_b.valid <= 1'b0;
    if (refuse)
    begin
      @(negedge mclk);
      check("refused", {p_ans.done, p_ans.err, p_stb}, 6'h3F);
      return;
    end
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check("addr", p_addr, kind[2] ? {10'h000, ad[15:0]} : ad);
    check("chip_en", p_ce, be ^ 2'h3);
    check("attr_sel", p_sel, !(kind[2] || kind[1]));
    check("strobes", p_stb, 4'hF ^ (4'h8 >> {kind[2], kind[0]}));
    if (kind[0])
      check("data_out", {p_doe, p_drv}, {1'b1, wd});
    else
      check("data_oe", p_doe, 1'b0);
    n = 0;
    while (p_ans.done !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    check("latency", n, 9);
    check("done_err", {p_ans.done, p_ans.err}, 2'h2);
    if (!kind[0])
      check("rdata", p_ans.rdata, old);
    else
      shadow[k] = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endtask : access

  // Strobe mix watched every cycle on both sockets
  always @(negedge mclk)
    if (rst_b)
    begin
      check("mix_a", mix_ok(sel_a, oe_a, we_a, ior_a, iow_a), 1'b1);
      check("mix_b", mix_ok(sel_b, oe_b, we_b, ior_b, iow_b), 1'b1);
    end

  // Main sequence: corners, random traffic, then strap high
  initial
  begin
    logic [31:0] r;
    logic [31:0] r2;
    logic [2:0] kd;
    restart(1'b0);
    // Every kind code on both sockets, socket A at address zero, socket B at all ones
    for (int i = 0; i < 16; i++)
      access(i[0], i[3:1], {26{i[0]}}, {4{i[3:0]}}, 2'h3, i[3:1] > 3'h5);
    // Narrow address mask so reads land on earlier writes
    for (int j = 0; j < 60; j++)
    begin
      r = $random(seed);
      r2 = $random(seed);
      kd = r[10:8];
      if (kd > 3'h5)
        kd = kd - 3'h2;
      access(r[0], kd, r[31:6] & 26'h300000F, r2[15:0], kd[0] ? r[2:1] : 2'h3, 1'b0);
    end
    // Strap high: socket A refused, socket B still serves
    restart(1'b1);
    access(1'b0, 3'h0, 26'h0000001, 16'h0000, 2'h3, 1'b1);
    access(1'b0, 3'h5, 26'h0000002, 16'h00FF, 2'h3, 1'b1);
    access(1'b1, 3'h1, 26'h0000005, 16'h1234, 2'h1, 1'b0);
    access(1'b1, 3'h0, 26'h0000005, 16'h0000, 2'h3, 1'b0);
    tally_and_finish();
  end

  // Watchdog: about four times the expected run of some 1,300 cycles
  initial
  begin
    #50000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_pcss_top
